/* File: include/hrp_pkg.sv */
package hrp_pkg;
  localparam int NUM_PORTS = 4;
  // field positions inside the port status and control word
  localparam int TEST_CTL_LSB = 16;
  localparam int IND_CTL_LSB = 14;
  localparam int OWNER_BIT = 13;
  localparam int POWER_BIT = 12;
  localparam int LINE_ST_LSB = 10;
  // reset values
  localparam logic [3:0] TEST_CTL_RST = 4'h0;
  localparam logic [1:0] IND_CTL_RST = 2'h0;
  localparam logic OWNER_RST = 1'h1;
  localparam logic POWER_RST = 1'h0;
  // indicator encodings
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_AMBER = 2'h1;
  localparam logic [1:0] IND_GREEN = 2'h2;
  localparam logic [1:0] IND_UNDEF = 2'h3;
  // test mode encodings
  localparam logic [3:0] TEST_NORMAL = 4'h0;
  localparam logic [3:0] TEST_J_STATE = 4'h1;
  localparam logic [3:0] TEST_K_STATE = 4'h2;
  localparam logic [3:0] TEST_SE0_NAK = 4'h3;
  localparam logic [3:0] TEST_PACKET = 4'h4;
  localparam logic [3:0] TEST_FORCE_EN = 4'h5;

  typedef struct packed {
    logic [3:0] test_ctl;
    logic [1:0] ind;
    logic owner;
    logic power;
  } hrp_port_t;

  localparam hrp_port_t PORT_RST = '{test_ctl: TEST_CTL_RST, ind: IND_CTL_RST,
                                     owner: OWNER_RST, power: POWER_RST};
endpackage

/* File: src/hrp_port_ctrl.sv */
`timescale 1ns/1ns
// Function
// - indicator writes ignored without indicator capability
// - indicator field drives off, amber, green
// - indicator field resets to off
// - configured flag rising clears ownership bit
// - ownership bit one while unconfigured, reset one
// - ownership bit one routes port to companion
// - no power switches: power reads one always
// - with switches, power bit controls switch
// - unpowered port reports no line status
// - overcurrent on powered port clears power
// - test field selects test mode, reserved selects normal
module hrp_port_ctrl #(
  parameter int NUM_PORTS = hrp_pkg::NUM_PORTS,
  localparam int IDX_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic indicator_cap_in,
  input wire logic power_switch_cap_in,
  input wire logic configured_flag_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_port_in,
  input wire logic [31:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [IDX_W-1:0] rd_port_in,
  input wire logic [NUM_PORTS*2-1:0] line_state_in,
  input wire logic [NUM_PORTS-1:0] overcurrent_in,
  output logic [31:0] rd_data_out,
  output logic rd_valid_out,
  output logic [NUM_PORTS-1:0] amber_out,
  output logic [NUM_PORTS-1:0] green_out,
  output logic [NUM_PORTS-1:0] companion_route_out,
  output logic [NUM_PORTS-1:0] port_power_out,
  output logic [NUM_PORTS*4-1:0] test_mode_out
);

  hrp_pkg::hrp_port_t st_r [NUM_PORTS];
  hrp_pkg::hrp_port_t st_nxt [NUM_PORTS];
  logic cfg_prev_r;
  wire cfg_rise = configured_flag_in && !cfg_prev_r;
  logic [NUM_PORTS-1:0] pwr_eff;
  logic [NUM_PORTS*2-1:0] ind_all;
  logic [NUM_PORTS-1:0] owner_all;
  logic [NUM_PORTS-1:0] amber_nxt;
  logic [NUM_PORTS-1:0] green_nxt;
  logic [NUM_PORTS*4-1:0] test_nxt;
  wire [31:0] rd_word;

  function automatic logic [3:0] test_sel(input logic [3:0] code);
    // reserved codes fall back to normal operation
    test_sel = (code <= hrp_pkg::TEST_FORCE_EN) ? code : hrp_pkg::TEST_NORMAL;
  endfunction

  function automatic logic [31:0] build_word(input hrp_pkg::hrp_port_t s,
                                             input logic pwr,
                                             input logic [1:0] ls);
    logic [31:0] w;
    w = 32'h0;
    w[hrp_pkg::TEST_CTL_LSB +: 4] = s.test_ctl;
    w[hrp_pkg::IND_CTL_LSB +: 2] = s.ind;
    w[hrp_pkg::OWNER_BIT] = s.owner;
    w[hrp_pkg::POWER_BIT] = pwr;
    // line levels are meaningless on an unpowered port
    w[hrp_pkg::LINE_ST_LSB +: 2] = pwr ? ls : 2'h0;
    build_word = w;
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      st_nxt[i] = st_r[i];
      if (wr_en_in && wr_port_in == IDX_W'(i)) begin
        if (indicator_cap_in) begin
          st_nxt[i].ind = wr_data_in[hrp_pkg::IND_CTL_LSB +: 2];
        end
        st_nxt[i].test_ctl = wr_data_in[hrp_pkg::TEST_CTL_LSB +: 4];
        if (power_switch_cap_in) begin
          st_nxt[i].power = wr_data_in[hrp_pkg::POWER_BIT];
        end
        st_nxt[i].owner = wr_data_in[hrp_pkg::OWNER_BIT];
      end
      // overcurrent on a powered port beats a software write in the same cycle
      if (power_switch_cap_in && st_r[i].power && overcurrent_in[i]) begin
        st_nxt[i].power = 1'h0;
      end
      // the flag edge is unconditional, so it beats a write too
      if (cfg_rise) begin
        st_nxt[i].owner = 1'h0;
      end
      if (!configured_flag_in) begin
        st_nxt[i].owner = 1'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      pwr_eff[i] = !power_switch_cap_in || st_r[i].power;
      ind_all[i*2 +: 2] = st_r[i].ind;
      owner_all[i] = st_r[i].owner;
      amber_nxt[i] = indicator_cap_in && st_r[i].ind == hrp_pkg::IND_AMBER;
      green_nxt[i] = indicator_cap_in && st_r[i].ind == hrp_pkg::IND_GREEN;
      test_nxt[i*4 +: 4] = test_sel(st_r[i].test_ctl);
    end
  end

  assign rd_word = build_word(st_r[rd_port_in], pwr_eff[rd_port_in],
                              line_state_in[rd_port_in*2 +: 2]);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        st_r[i] <= hrp_pkg::PORT_RST;
      end
      // a flag already high at reset release counts as a rise
      cfg_prev_r <= 1'h0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        st_r[i] <= st_nxt[i];
      end
      cfg_prev_r <= configured_flag_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h0;
      rd_valid_out <= 1'h0;
      amber_out <= '0;
      green_out <= '0;
      companion_route_out <= '1;
      port_power_out <= '0;
      test_mode_out <= '0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= rd_word;
      end
      amber_out <= amber_nxt;
      green_out <= green_nxt;
      companion_route_out <= owner_all;
      port_power_out <= pwr_eff;
      test_mode_out <= test_nxt;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence oc_hit0;
    power_switch_cap_in && overcurrent_in[0] && st_r[0].power;
  endsequence
  sequence power_drops0;
    !st_r[0].power ##1 !port_power_out[0];
  endsequence
  sequence cfg_rise0;
    $rose(configured_flag_in) && !cfg_prev_r;
  endsequence
  sequence owners_clear;
    owner_all == '0 ##1 companion_route_out == '0;
  endsequence

  // indicator field and leds
  chk_ind_no_write: assert property (!indicator_cap_in |=>
    ind_all == $past(ind_all))
    else $error("indicator field changed without capability");
  chk_ind_write: assert property ((indicator_cap_in && wr_en_in && wr_port_in == '0)
    |=> st_r[0].ind == $past(wr_data_in[hrp_pkg::IND_CTL_LSB +: 2]))
    else $error("indicator write not taken");
  chk_led_amber: assert property ((indicator_cap_in && st_r[0].ind == hrp_pkg::IND_AMBER)
    |=> amber_out[0] && !green_out[0])
    else $error("amber selection not shown");
  chk_led_green: assert property ((indicator_cap_in && st_r[0].ind == hrp_pkg::IND_GREEN)
    |=> green_out[0] && !amber_out[0])
    else $error("green selection not shown");
  chk_led_off: assert property (st_r[0].ind == hrp_pkg::IND_OFF
    |=> !amber_out[0] && !green_out[0])
    else $error("off code lit a led");
  chk_led_undef: assert property (st_r[0].ind == hrp_pkg::IND_UNDEF
    |=> !amber_out[0] && !green_out[0])
    else $error("undefined indicator code lit a led");
  chk_reset_state: assert property (disable iff (1'h0)
    !rst_n_in |=> ind_all == '0 && &owner_all)
    else $error("bad indicator or owner after reset");

  // ownership hand-off
  chk_cfg_rise_clear: assert property (cfg_rise0 |=> owners_clear)
    else $error("owner not cleared on configured rise");
  chk_cfg_low_owner: assert property (!configured_flag_in |=>
    &owner_all)
    else $error("owner not forced while unconfigured");
  chk_owner_write: assert property ((wr_en_in && wr_port_in == '0 && configured_flag_in
    && cfg_prev_r) |=> st_r[0].owner == $past(wr_data_in[hrp_pkg::OWNER_BIT]))
    else $error("owner write not taken");
  chk_route_owner: assert property (st_r[0].owner |=>
    companion_route_out[0])
    else $error("owned port not routed to companion");

  // port power and status
  chk_power_fixed: assert property (!power_switch_cap_in |=>
    &port_power_out)
    else $error("power not fixed on without switches");
  chk_power_write: assert property ((power_switch_cap_in && wr_en_in && wr_port_in == '0
    && !overcurrent_in[0]) |=> st_r[0].power == $past(wr_data_in[hrp_pkg::POWER_BIT]))
    else $error("power write not taken");
  chk_line_masked: assert property ((rd_en_in && !pwr_eff[rd_port_in])
    |=> rd_valid_out && rd_data_out[hrp_pkg::LINE_ST_LSB +: 2] == 2'h0)
    else $error("line status reported on unpowered port");
  chk_oc_off: assert property (oc_hit0 |=> power_drops0)
    else $error("overcurrent did not remove power");

  // test modes and port separation
  chk_test_pass: assert property (st_r[0].test_ctl <= hrp_pkg::TEST_FORCE_EN
    |=> test_mode_out[3:0] == $past(st_r[0].test_ctl))
    else $error("defined test code not applied");
  chk_test_rsvd: assert property (st_r[0].test_ctl > hrp_pkg::TEST_FORCE_EN
    |=> test_mode_out[3:0] == hrp_pkg::TEST_NORMAL)
    else $error("reserved test code applied");
  chk_port_isolate: assert property ((wr_en_in && wr_port_in != '0 && configured_flag_in
    && cfg_prev_r && !overcurrent_in[0]) |=> $stable(st_r[0]))
    else $error("port 0 changed by another port write");

endmodule // hrp_port_ctrl

/* File: verification/tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic clk_in, rst_n_in, ind_cap, psw_cap, cfg_flag, wr_en, rd_en, rd_valid;
  logic [1:0] wr_port, rd_port;
  logic [31:0] wr_data, rd_data;
  logic [7:0] line_st;
  logic [3:0] oc, amber, green, route, power;
  logic [15:0] tmode;
  int errors, tests_run;
  hrp_port_ctrl hrp_port_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .indicator_cap_in(ind_cap), .power_switch_cap_in(psw_cap), .configured_flag_in(cfg_flag),
    .wr_en_in(wr_en), .wr_port_in(wr_port), .wr_data_in(wr_data), .rd_en_in(rd_en),
    .rd_port_in(rd_port), .line_state_in(line_st), .overcurrent_in(oc), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .amber_out(amber), .green_out(green),
    .companion_route_out(route), .port_power_out(power), .test_mode_out(tmode));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic summarize();
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] word(logic [3:0] t, logic [1:0] i, logic o, logic p,
                                       logic [1:0] l);
    return {12'h000, t, i, o, p, l, 10'h000};
  endfunction
  // waits past the state edge and the output edge
  task automatic wr(input logic [1:0] p, input logic [31:0] d);
    wr_port = p;
    wr_data = d;
    wr_en = 1'h1;
    @(negedge clk_in);
    wr_en = 1'h0;
    @(negedge clk_in);
  endtask
  // one idle cycle after each read so back-to-back calls never re-raise the strobe
  task automatic rd(input logic [1:0] p, input logic [31:0] e);
    rd_port = p;
    rd_en = 1'h1;
    @(negedge clk_in);
    rd_en = 1'h0;
    `CHK(rd_valid, 1'h1)
    `CHK(rd_data, e)
    @(negedge clk_in);
  endtask
  initial begin
    #20000;
    errors++;
    summarize();
  end
  initial begin
    {rst_n_in, ind_cap, psw_cap, cfg_flag, wr_en, rd_en, wr_port, rd_port, oc} = '0;
    wr_data = 32'h0;
    line_st = 8'h1b; // port 0 = 11, 1 = 10, 2 = 01, 3 = 00
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'h1;
    @(negedge clk_in);
    `CHK(route, 4'hf)
    `CHK(amber | green, 4'h0)
    rd(2'h0, word(4'h0, 2'h0, 1'h1, 1'h1, 2'h3));
    `CHK(power, 4'hf)
    wr(2'h1, word(4'h0, 2'h0, 1'h1, 1'h1, 2'h0));
    rd(2'h0, word(4'h0, 2'h0, 1'h1, 1'h1, 2'h3));
    psw_cap = 1'h1;
    @(negedge clk_in);
    `CHK(power, 4'h0)
    wr(2'h2, word(4'h0, 2'h0, 1'h0, 1'h1, 2'h0));
    `CHK(power, 4'h4)
    `CHK(route, 4'hf)
    rd(2'h2, word(4'h0, 2'h0, 1'h1, 1'h1, 2'h1));
    rd(2'h0, word(4'h0, 2'h0, 1'h1, 1'h0, 2'h0));
    oc = 4'hf;
    repeat (2) @(negedge clk_in);
    oc = 4'h0;
    `CHK(power, 4'h0)
    wr(2'h0, word(4'h0, hrp_pkg::IND_AMBER, 1'h1, 1'h0, 2'h0));
    `CHK(amber, 4'h0)
    rd(2'h0, word(4'h0, 2'h0, 1'h1, 1'h0, 2'h0));
    ind_cap = 1'h1;
    for (int i = 0; i < 4; i++) begin
      wr(2'h3, word(4'h0, 2'(i), 1'h1, 1'h0, 2'h0));
      `CHK(amber, {(i == 1), 3'h0})
      `CHK(green, {(i == 2), 3'h0})
    end
    // reserved test codes must not reach the port
    for (int t = 0; t < 8; t++) begin
      wr(2'h1, word(4'(t), 2'h0, 1'h1, 1'h0, 2'h0));
      `CHK(tmode[7:4], (t < 6) ? 4'(t) : 4'h0)
    end
    cfg_flag = 1'h1;
    repeat (3) @(negedge clk_in);
    `CHK(route, 4'h0)
    // software looks at the line levels before handing a slow device over
    wr(2'h2, word(4'h0, 2'h0, 1'h0, 1'h1, 2'h0));
    rd(2'h2, word(4'h0, 2'h0, 1'h0, 1'h1, 2'h1));
    wr(2'h2, word(4'h0, 2'h0, 1'h1, 1'h1, 2'h0));
    `CHK(route, 4'h4)
    wr(2'h1, word(4'h0, 2'h0, 1'h1, 1'h0, 2'h0));
    `CHK(route, 4'h6)
    rd(2'h1, word(4'h0, 2'h0, 1'h1, 1'h0, 2'h0));
    cfg_flag = 1'h0;
    repeat (2) @(negedge clk_in);
    `CHK(route, 4'hf)
    summarize();
  end
endmodule // tb
